// *** rtl/spm_consts.vh ***
// Purpose: constants for the serial port block (modes 0 to 3, baud generation)
// Assumes: 32-bit classic Wishbone, byte data in bits 7:0, word-aligned registers
// Notes: shared by spm_serial_port.v and by the test checker and bench
//
// Function
// RL1 - mode 0 bit rate is the clock divided by six
// RL2 - mode 2 rate is clock/32, or clock/16 with baud_double set
// RL3 - modes 1 and 3 rate from timer 1 overflow, /192 or /96
// RL4 - software disables timer 1 interrupt and sets timer mode nibble 0010
// RL5 - mode 0 buffer write loads marker; sending starts one machine cycle later
// RL6 - mode 0 shift clock low in states 3-5, high in 6,1,2
// RL7 - mode 0 shifts right at state 6; marker left of msb ends send
// RL8 - mode 0 receive begins when enabled and flag clear; loads 11111110
// RL9 - mode 0 receive shifts left at state 6 with state 5 sample
// RL10 - mode 0 receive ends when initial zero reaches top; loads buffer
// RL11 - mode 1 frame: start 0, eight data lsb first, stop 1
// RL12 - mode 1 write loads marker; send starts after next divide-by-16 rollover
// RL13 - mode 1 start bit first, data enabled one bit later, shift after
// RL14 - mode 1 marker left of output bit ends send and sets flag
// RL15 - mode 1 line sampled at 16x; falling edge resets counter, loads 1ff
// RL16 - bit value is majority of samples at counter states 7, 8, 9
// RL17 - a start bit not accepted as 0 restarts edge search
// RL18 - final shift commits only if receive flag clear and stop check passes
// RL19 - commit stores stop bit, data byte and sets receive flag
// RL20 - failed commit drops the frame; edge search resumes either way
// RL21 - buffer writes go to transmit, reads come from separate receive register
// RL22 - modes 1 to 3 receive only on start bit while receive enabled
// RL23 - interrupt request stands while transmit or receive flag is set
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SPM_ADR_BUF 8'h00
`define SPM_ADR_CTL 8'h04
`define SPM_ADR_PWR 8'h08
`define SPM_ADR_TIMER_MODE_REG 8'h0c
`define SPM_ADR_RELOAD 8'h10
`define SPM_ADR_STAT 8'h14

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define SPM_CTL_RESET 8'h00
`define SPM_BIT_RI 0
`define SPM_BIT_TI 1
`define SPM_BIT_RB8 2
`define SPM_BIT_TB8 3
`define SPM_BIT_REN 4
`define SPM_BIT_MPE 5
`define SPM_BIT_DBL 7
`define SPM_TIMER_MODE_REG_AUTO 4'h2
`define SPM_MODE0 2'd0
`define SPM_MODE2 2'd2

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SPM_STATES 3'd6
`define SPM_ST_FIRST 3'd1
`define SPM_T1_TOP 8'hff
`define SPM_ST_CLK_LO 3'd3
`define SPM_ST_CLK_HI 3'd6
`define SPM_ST_SAMPLE 3'd5
`define SPM_DIV_LAST 4'hf
`define SPM_SMP_A 4'h7
`define SPM_SMP_B 4'h8
`define SPM_SMP_C 4'h9
`define SPM_TX_LOAD 9'h100
`define SPM_RX1_INIT 9'h1ff
`define SPM_RX0_INIT 8'hfe

`endif

// *** rtl/spm_serial_port.v ***
// Purpose: serial port, shift-register mode 0 and async modes 1 to 3, with baud generation
// Assumes: clk_i is the cpu clock, one machine state per clock, six states per machine cycle
// Notes: modes 2 and 3 reuse the 10-bit frame; only mode 2's bit rate differs from mode 1
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/100ps
`include "spm_consts.vh"

module spm_serial_port
(
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg port1_bit0_pin_o,
	input wire port1_bit1_pin_i,
	output reg port1_bit1_pin_o,
	output reg port1_bit1_pin_oe_o,
	output wire serial_irq_o
);

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	reg [7:0] serial_control_reg;
	reg [7:0] power_control_reg;
	reg [7:0] timer_mode_reg;
	reg [7:0] reload;
	reg [7:0] rx_buffer;
	reg [7:0] t1_count;
	reg [7:0] rx0_sr;
	reg [2:0] mstate;
	reg [8:0] tx_sr;
	reg [8:0] rx1_sr;
	reg [3:0] tx_div;
	reg [3:0] rx_div;
	reg t1_half, div2;
	reg tx_req, send, data_ph;
	reg rx_arm, rx_active, rx_smp;
	reg rx_busy, rx_first;
	reg smp_a, smp_b, line_prev;
	reg sync1, sync2, sync3, line_lvl;

	wire [1:0] mode = serial_control_reg[7:6];
	wire mode0 = (mode == `SPM_MODE0);
	wire dbl = power_control_reg[`SPM_BIT_DBL];
	wire ren = serial_control_reg[`SPM_BIT_REN];
	wire mpe = serial_control_reg[`SPM_BIT_MPE];
	wire ri = serial_control_reg[`SPM_BIT_RI];
	wire ti = serial_control_reg[`SPM_BIT_TI];

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// a request is taken once; ack drops the cycle after it is given
	wire bus_go = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr_go = bus_go && wb_we_i && wb_sel_i[0];
	wire wr_buf = wr_go && (wb_adr_i == `SPM_ADR_BUF);
	wire wr_ctl = wr_go && (wb_adr_i == `SPM_ADR_CTL);

	// ----------------------------------------------------------------
	// machine cycle and timer 1
	// ----------------------------------------------------------------
	wire st6_end = (mstate == `SPM_STATES); // state 6, phase 2 edge
	wire t1_run = (timer_mode_reg[7:4] == `SPM_TIMER_MODE_REG_AUTO); // RL4
	wire t1_ovf = t1_run && st6_end && (t1_count == `SPM_T1_TOP);

	// 16x tick: timer overflow (halved unless doubled) or clk/2 or clk/1
	wire tick16 = (mode == `SPM_MODE2) ? (dbl | div2) // RL2
		: (t1_ovf && (dbl || t1_half)); // RL3

	// machine state counter runs 1..6; timer counts machine cycles
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mstate <= `SPM_ST_FIRST;
			t1_count <= 8'h00;
			t1_half <= 1'b0;
			div2 <= 1'b0;
		end
		else if (ce_i)
		begin
			mstate <= st6_end ? `SPM_ST_FIRST : mstate + 3'd1; // RL1
			div2 <= ~div2;
			if (t1_run && st6_end)
				t1_count <= (t1_count == `SPM_T1_TOP) ? reload : t1_count + 8'h01;
			if (t1_ovf)
				t1_half <= ~t1_half;
		end
	end

	// ----------------------------------------------------------------
	// input synchroniser
	// ----------------------------------------------------------------
	// the level moves only when the second and third stages agree
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			sync3 <= 1'b1;
			line_lvl <= 1'b1;
		end
		else if (ce_i)
		begin
			sync1 <= port1_bit1_pin_i;
			sync2 <= sync1;
			sync3 <= sync2;
			if (sync2 == sync3)
				line_lvl <= sync3;
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	wire tx_roll = tick16 && (tx_div == `SPM_DIV_LAST);
	wire tx_last = (tx_sr[8:1] == 8'h01); // marker just left of output
	wire tx_done = send && tx_last // RL7
		&& (mode0 ? st6_end : (data_ph && tx_roll)); // RL14

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_sr <= 9'h000;
			tx_req <= 1'b0;
			send <= 1'b0;
			data_ph <= 1'b0;
			tx_div <= 4'h0;
		end
		else if (ce_i)
		begin
			if (tick16)
				tx_div <= tx_div + 4'h1;
			if (wr_buf)
			begin
				// marker 1 in the ninth position, data below
				tx_sr <= `SPM_TX_LOAD | {1'b0, wb_dat_i[7:0]}; // RL5 RL12
				tx_req <= 1'b1;
				send <= 1'b0;
				data_ph <= 1'b0;
			end
			else if (mode0)
			begin
				// sending starts at the next state 6 edge, then shifts each cycle
				if (tx_req && st6_end)
				begin
					tx_req <= 1'b0;
					send <= 1'b1; // RL5
				end
				else if (send && st6_end)
				begin
					tx_sr <= {1'b0, tx_sr[8:1]}; // RL7
					if (tx_last)
						send <= 1'b0;
				end
			end
			else if (tx_roll)
			begin
				// bit times follow the divide-by-16 counter, not the write
				if (tx_req)
				begin
					tx_req <= 1'b0;
					send <= 1'b1; // RL12 RL13
				end
				else if (send && !data_ph)
					data_ph <= 1'b1; // RL13
				else if (send)
				begin
					tx_sr <= {1'b0, tx_sr[8:1]}; // RL13
					if (tx_last)
					begin
						send <= 1'b0; // RL14
						data_ph <= 1'b0;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// mode 0 receiver
	// ----------------------------------------------------------------
	wire rx0_last = !rx0_sr[7];
	wire [7:0] rx0_next = {rx0_sr[6:0], rx_smp};
	wire rx0_done = mode0 && rx_active && st6_end && rx0_last;
	// left shift lands the first bit on top; reverse for lsb-first byte
	wire [7:0] rx0_rev = {rx0_next[0], rx0_next[1], rx0_next[2], rx0_next[3],
		rx0_next[4], rx0_next[5], rx0_next[6], rx0_next[7]};

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_arm <= 1'b0;
			rx_active <= 1'b0;
			rx0_sr <= 8'hff;
			rx_smp <= 1'b1;
		end
		else if (ce_i)
		begin
			if (mstate == `SPM_ST_SAMPLE)
				rx_smp <= line_lvl; // RL9
			if (!mode0 || !ren)
			begin
				rx_arm <= 1'b0;
				rx_active <= 1'b0;
			end
			else if (!rx_active && !rx_arm && !ri)
				rx_arm <= 1'b1; // RL8
			else if (rx_arm && st6_end)
			begin
				rx_arm <= 1'b0;
				rx0_sr <= `SPM_RX0_INIT; // RL8
				rx_active <= 1'b1;
			end
			else if (rx_active && st6_end)
			begin
				rx0_sr <= rx0_next; // RL9
				if (rx0_last)
					rx_active <= 1'b0; // RL10
			end
		end
	end

	// ----------------------------------------------------------------
	// modes 1 to 3 receiver
	// ----------------------------------------------------------------
	wire maj = (smp_a & smp_b) | (smp_a & line_lvl) | (smp_b & line_lvl); // RL16
	wire rx_bit = rx_busy && tick16 && (rx_div == `SPM_SMP_C);
	wire rx1_last = !rx1_sr[0]; // start bit at the far end
	wire [8:0] rx1_next = {maj, rx1_sr[8:1]};
	wire rx1_done = rx_bit && !rx_first && rx1_last;
	wire rx1_ok = !ri && (!mpe || maj); // RL18

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx1_sr <= `SPM_RX1_INIT;
			rx_busy <= 1'b0;
			rx_first <= 1'b0;
			rx_div <= 4'h0;
			smp_a <= 1'b1;
			smp_b <= 1'b1;
			line_prev <= 1'b1;
		end
		else if (ce_i)
		begin
			if (tick16)
				line_prev <= line_lvl;
			if (mode0 || (!ren && !rx_busy))
				rx_busy <= 1'b0;
			else if (!rx_busy)
			begin
				// edge search at the 16x rate
				if (tick16 && ren && line_prev && !line_lvl)
				begin
					rx_div <= 4'h0; // RL15 RL22
					rx1_sr <= `SPM_RX1_INIT; // RL15
					rx_busy <= 1'b1;
					rx_first <= 1'b1;
				end
			end
			else if (tick16)
			begin
				rx_div <= rx_div + 4'h1;
				if (rx_div == `SPM_SMP_A)
					smp_a <= line_lvl; // RL16
				if (rx_div == `SPM_SMP_B)
					smp_b <= line_lvl; // RL16
				if (rx_div == `SPM_SMP_C)
				begin
					rx_first <= 1'b0;
					if (rx_first && maj)
						rx_busy <= 1'b0; // RL17
					else
						rx1_sr <= rx1_next; // RL11
					if (!rx_first && rx1_last)
						rx_busy <= 1'b0; // RL20
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// control registers, flags and receive buffer
	// ----------------------------------------------------------------
	// hardware set wins over a software clear in the same cycle
	wire ti_set = tx_done;
	wire ri_set = rx0_done || (rx1_done && rx1_ok);

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			serial_control_reg <= `SPM_CTL_RESET;
			power_control_reg <= 8'h00;
			timer_mode_reg <= 8'h00;
			reload <= 8'h00;
			rx_buffer <= 8'h00;
		end
		else if (ce_i)
		begin
			if (wr_ctl)
				serial_control_reg <= wb_dat_i[7:0];
			if (wr_go && (wb_adr_i == `SPM_ADR_PWR))
				power_control_reg <= wb_dat_i[7:0];
			if (wr_go && (wb_adr_i == `SPM_ADR_TIMER_MODE_REG))
				timer_mode_reg <= wb_dat_i[7:0];
			if (wr_go && (wb_adr_i == `SPM_ADR_RELOAD))
				reload <= wb_dat_i[7:0];
			if (ti_set)
				serial_control_reg[`SPM_BIT_TI] <= 1'b1; // RL7 RL14
			if (rx0_done)
				rx_buffer <= rx0_rev; // RL10
			if (rx1_done && rx1_ok)
			begin
				rx_buffer <= rx1_next[7:0]; // RL19
				serial_control_reg[`SPM_BIT_RB8] <= rx1_next[8]; // RL11 RL19
			end
			if (ri_set)
				serial_control_reg[`SPM_BIT_RI] <= 1'b1; // RL10 RL19
		end
	end

	assign serial_irq_o = ti | ri; // RL23

	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	// unmapped offsets still answer, reading zero, so the bus never hangs
	reg [7:0] rd_byte;
	always @*
	begin
		case (wb_adr_i)
			`SPM_ADR_BUF: rd_byte = rx_buffer; // RL21
			`SPM_ADR_CTL: rd_byte = serial_control_reg;
			`SPM_ADR_PWR: rd_byte = power_control_reg;
			`SPM_ADR_TIMER_MODE_REG: rd_byte = timer_mode_reg;
			`SPM_ADR_RELOAD: rd_byte = reload;
			`SPM_ADR_STAT: rd_byte = {3'b000, rx_busy, rx_active, data_ph, send, tx_req};
			default: rd_byte = 8'h00;
		endcase
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else if (ce_i)
		begin
			wb_ack_o <= bus_go;
			if (bus_go)
				wb_dat_o <= {24'h000000, rd_byte};
		end
	end

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	// mode 0: pin 0 is the shift clock, pin 1 two-way data
	wire clk_lo = (mstate >= `SPM_ST_CLK_LO) && (mstate < `SPM_ST_CLK_HI);
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			port1_bit0_pin_o <= 1'b1;
			port1_bit1_pin_o <= 1'b1;
			port1_bit1_pin_oe_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (mode0)
			begin
				port1_bit0_pin_o <= !((send || rx_active) && clk_lo); // RL6
				port1_bit1_pin_o <= tx_sr[0]; // RL6
				port1_bit1_pin_oe_o <= send;
			end
			else
			begin
				// idle high, start bit low, then shift register output
				port1_bit0_pin_o <= !send || (data_ph && tx_sr[0]); // RL11 RL13
				port1_bit1_pin_o <= 1'b1;
				port1_bit1_pin_oe_o <= 1'b0;
			end
		end
	end

endmodule

// *** test/spm_serial_port_checker.sv ***
// Purpose: port-level checks for the serial port
// Assumes: ce_i is held high by the bench
// Notes: bound into every instance of the port
`timescale 1ns/100ps
`include "spm_consts.vh"
module spm_serial_port_checker
(
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire port1_bit0_pin_o,
	input wire port1_bit1_pin_i,
	input wire port1_bit1_pin_o,
	input wire port1_bit1_pin_oe_o,
	input wire serial_irq_o
);
	int ocnt = 0;
	// length of a mode 0 send, counted while the data pin is driven
	always @(posedge clk_i)
		ocnt <= (rst_i || !port1_bit1_pin_oe_o) ? 0 : ocnt + 1;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_lo;
		!port1_bit0_pin_o [*3];
	endsequence
	sequence s_hi;
		port1_bit0_pin_o [*3];
	endsequence
	AST_ACK_REQ: assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_RD_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_IRQ_READ: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == `SPM_ADR_CTL)
		|-> (|wb_dat_o[1:0]) == $past(serial_irq_o)) else $error("irq disagrees with flags");
	AST_SCLK_LOW: assert property ($fell(port1_bit0_pin_o) && port1_bit1_pin_oe_o
		|-> s_lo ##1 port1_bit0_pin_o) else $error("shift clock low phase wrong");
	AST_SCLK_HIGH: assert property ($rose(port1_bit0_pin_o) && port1_bit1_pin_oe_o
		|-> s_hi) else $error("shift clock high phase wrong");
	AST_DATA_STABLE: assert property (port1_bit1_pin_oe_o && $past(port1_bit1_pin_oe_o)
		&& !port1_bit0_pin_o && $past(!port1_bit0_pin_o) |-> $stable(port1_bit1_pin_o))
		else $error("data moved while shift clock low");
	AST_SEND_LEN: assert property ($fell(port1_bit1_pin_oe_o) |-> ocnt inside {[45:51]})
		else $error("mode 0 send length wrong");
	AST_RST_VALS: assert property ($fell(rst_i) |-> !wb_ack_o && port1_bit0_pin_o
		&& !port1_bit1_pin_oe_o && !serial_irq_o) else $error("outputs not idle after reset");
endmodule
bind spm_serial_port spm_serial_port_checker chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.port1_bit0_pin_o(port1_bit0_pin_o), .port1_bit1_pin_i(port1_bit1_pin_i),
	.port1_bit1_pin_o(port1_bit1_pin_o), .port1_bit1_pin_oe_o(port1_bit1_pin_oe_o),
	.serial_irq_o(serial_irq_o));

// *** test/spm_far_dev.sv ***
// Purpose: far side: external shift register and remote async device
// Assumes: BIT clocks per async bit, as set by reload 8'hff with doubling
// Notes: drives the data line whenever the port releases it
`timescale 1ns/100ps
module spm_far_dev
#(
	parameter int BIT = 96
)
(
	input wire clk_i,
	input wire m0_i,
	input wire sclk_i,
	input wire oe_i,
	input wire d_i,
	output logic line_o
);
	logic [7:0] cap = 0;
	logic [7:0] cap0 = 0;
	logic [7:0] sh = 0;
	logic stop = 0;
	logic rxd = 1;
	// idle async line is high, like a pulled-up wire
	assign line_o = m0_i ? sh[0] : rxd;
	// shift register: take data on the falling clock, where it is stable
	always @(negedge sclk_i)
		if (m0_i && oe_i)
			cap0 <= {d_i, cap0[7:1]};
	// next bit out on rising clock; vacated bits toggle so stale data never matches
	always @(posedge sclk_i)
		if (m0_i && !oe_i)
			sh <= {~sh[0], sh[7:1]};
	// async receiver, samples mid-bit
	always @(negedge sclk_i)
		if (!m0_i)
		begin
			repeat (BIT / 2) @(posedge clk_i);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT) @(posedge clk_i);
				cap[i] = sclk_i;
			end
			repeat (BIT) @(posedge clk_i);
			stop = sclk_i;
		end
	// one frame: start 0, data lsb first, given stop level
	task automatic send(input logic [7:0] v, input logic s);
		logic [9:0] f;
		f = {s, v, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk_i);
			rxd <= f[i];
			repeat (BIT - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		rxd <= 1'b1;
	endtask
	// low pulse too short to survive the mid-bit vote
	task automatic glitch;
		@(posedge clk_i);
		rxd <= 1'b0;
		repeat (12) @(posedge clk_i);
		rxd <= 1'b1;
	endtask
endmodule

// *** test/spm_serial_port_tb.sv ***
// Purpose: self-checking bench for the serial port
// Assumes: async bit of 96 clocks (reload 8'hff, doubled)
// Notes: register rows first, then link cases
`timescale 1ns/100ps
`include "spm_consts.vh"
`define CHK(a, e) \
	begin \
		checks++; \
		if ((a) !== (e)) \
		begin \
			fail_count++; \
			$display("ERROR %0t got %h want %h", $time, a, e); \
		end \
	end
module spm_serial_port_tb;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} spm_row_t;
	logic clk_i = 0;
	logic rst_i = 1;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic m0 = 1;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0;
	logic [31:0] rdat;
	logic ack, sclk, d_o, d_oe, irq, far_d;
	logic [7:0] q;
	int fail_count = 0;
	int checks = 0;
	int n;
	spm_row_t rows[5] = '{'{`SPM_ADR_PWR, 8'h80, 8'h80}, '{`SPM_ADR_TIMER_MODE_REG, 8'h20, 8'h20},
		'{`SPM_ADR_RELOAD, 8'hff, 8'hff}, '{8'h1c, 8'h5a, 8'h00}, '{`SPM_ADR_STAT, 8'h1f, 8'h00}};
	// shared data pin: the port wins while it drives
	wire line = d_oe ? d_o : far_d;
	always #2 clk_i = ~clk_i;
	spm_serial_port dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .port1_bit0_pin_o(sclk), .port1_bit1_pin_i(line),
		.port1_bit1_pin_o(d_o), .port1_bit1_pin_oe_o(d_oe), .serial_irq_o(irq));
	spm_far_dev far (.clk_i(clk_i), .m0_i(m0), .sclk_i(sclk), .oe_i(d_oe), .d_i(d_o),
		.line_o(far_d));
	// one classic cycle; read data lands in q
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		`CHK(ack, 1'b1)
		q = rdat[7:0];
		cyc <= 0;
		stb <= 0;
	endtask
	// poll the control register until flag b is set
	task automatic wait_flag(input int b);
		int n;
		n = 0;
		do
		begin
			wb(0, `SPM_ADR_CTL, 0);
			n++;
		end
		while (q[b] !== 1'b1 && n < 2000);
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watchdog, several times the expected run
	initial
	begin
		#160000;
		fail_count++;
		end_sim;
	end
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		wb(0, `SPM_ADR_CTL, 0);
		`CHK(q, `SPM_CTL_RESET)
		`CHK(irq, 1'b0)
		foreach (rows[i])
		begin
			wb(1, rows[i].a, rows[i].d);
			wb(0, rows[i].a, 0);
			`CHK(q, rows[i].e)
		end
		// mode 0 transmit
		wb(1, `SPM_ADR_BUF, 8'ha5);
		wait_flag(`SPM_BIT_TI);
		`CHK(far.cap0, 8'ha5)
		`CHK(irq, 1'b1)
		// mode 0 receive; buffer read must show the receive side
		far.sh <= 8'h3c;
		wb(1, `SPM_ADR_CTL, 8'h10);
		wait_flag(`SPM_BIT_RI);
		`CHK(q[0], 1'b1)
		wb(0, `SPM_ADR_BUF, 0);
		`CHK(q, 8'h3c)
		wb(0, `SPM_ADR_STAT, 0);
		`CHK(q[3], 1'b0)
		// mode 1, both directions
		m0 <= 0;
		wb(1, `SPM_ADR_CTL, 8'h50);
		wb(1, `SPM_ADR_BUF, 8'h96);
		wait_flag(`SPM_BIT_TI);
		repeat (96) @(posedge clk_i);
		`CHK(far.cap, 8'h96)
		`CHK(far.stop, 1'b1)
		far.send(8'h5b, 1);
		wait_flag(`SPM_BIT_RI);
		`CHK(q[2], 1'b1)
		wb(0, `SPM_ADR_BUF, 0);
		`CHK(q, 8'h5b)
		far.send(8'h11, 1);
		wb(0, `SPM_ADR_BUF, 0);
		`CHK(q, 8'h5b)
		wb(1, `SPM_ADR_CTL, 8'h70);
		far.send(8'h22, 0);
		wb(0, `SPM_ADR_CTL, 0);
		`CHK(q[0], 1'b0)
		far.glitch;
		repeat (1200) @(posedge clk_i);
		wb(0, `SPM_ADR_CTL, 0);
		`CHK(q[0], 1'b0)
		far.send(8'hc3, 1);
		wait_flag(`SPM_BIT_RI);
		wb(0, `SPM_ADR_BUF, 0);
		`CHK(q, 8'hc3)
		wb(1, `SPM_ADR_CTL, 8'h40);
		far.send(8'h77, 1);
		wb(0, `SPM_ADR_CTL, 0);
		`CHK(q[0], 1'b0)
		// mode 2: start bit is 16 ticks of clk/1 (doubled) or clk/2
		wb(1, `SPM_ADR_CTL, 8'h80);
		for (int k = 0; k < 2; k++)
		begin
			wb(1, `SPM_ADR_PWR, k ? 8'h00 : 8'h80);
			wb(1, `SPM_ADR_BUF, 8'hff);
			n = 0;
			while (sclk !== 1'b0 && n < 100)
			begin
				@(posedge clk_i);
				n++;
			end
			n = 0;
			while (sclk === 1'b0 && n < 100)
			begin
				@(posedge clk_i);
				n++;
			end
			`CHK(n, k ? 32 : 16)
		end
		end_sim;
	end
endmodule
